/* File: hw/ees_dev.sv */
// Slave end: 512-byte serial memory with page buffer, clocked by the link clock
// Notes on behaviour
// - 512 bytes as 32 pages of 16
// - One page buffer, committed in one cycle
// - Works up to 100 or 400 kHz
// - Write-protect high blocks all writes
// - Select pins default low
// - Respond only when select bits match pins
// - Sample on rise, change after fall
// - Data output only pulls low
// - Master makes clock, start, stop
// - Reject glitches shorter than 0.1 us
// - Ready within 1 ms after power
// - Reset abandons transfer, then standby
// - Address byte: type, select, high bit, direction
// - Acknowledge address and written bytes
// - Write pointer wraps inside page
// - No address acknowledge while writing
module ees_dev #(
    parameter int unsigned WRITE_CYC = ees_pkg::WRITE_CYC,
    parameter logic [3:0]  TYPE_CODE = ees_pkg::TYPE_CODE_DEF
) (
    ees_if.dev               bus,
    input  wire logic        i_rst_n,
    input  wire logic        i_wp,
    input  wire logic [1:0]  i_sel,
    output logic             o_busy
);
    localparam int unsigned BW = $clog2(WRITE_CYC + 1);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_WADDR,
        ST_WDATA,
        ST_READ,
        ST_IGNORE
    } ees_dst_type;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Bits: 0 scl, 1 sda, 3:2 select, 4 write protect
    logic [4:0] syn1_reg;
    logic [4:0] syn2_reg;

    always_ff @(posedge bus.link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            // Bus bits reset to the pulled-up idle level so no false edge follows reset
            syn1_reg <= 5'h03;
            syn2_reg <= 5'h03;
        end else begin
            syn1_reg <= {i_wp, i_sel, bus.sda, bus.scl};
            syn2_reg <= syn1_reg;
        end
    end

    // ------------------------------------------------------------
    // Glitch filter and edge detect
    // ------------------------------------------------------------
    logic [1:0] flt_reg;
    logic [1:0] flt_next;
    logic [1:0] prv_reg;
    logic [1:0] fcnt_reg [2];
    logic [1:0] fcnt_next [2];

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            flt_next[i]  = flt_reg[i];
            fcnt_next[i] = 2'h0;
            if (syn2_reg[i] != flt_reg[i]) begin
                if (fcnt_reg[i] == 2'(ees_pkg::FILT_CYC)) begin
                    flt_next[i] = syn2_reg[i];
                end else begin
                    fcnt_next[i] = fcnt_reg[i] + 2'h1;
                end
            end
        end
    end

    always_ff @(posedge bus.link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flt_reg     <= 2'h3;
            prv_reg     <= 2'h3;
            fcnt_reg[0] <= 2'h0;
            fcnt_reg[1] <= 2'h0;
        end else begin
            flt_reg     <= flt_next;
            prv_reg     <= flt_reg;
            fcnt_reg[0] <= fcnt_next[0];
            fcnt_reg[1] <= fcnt_next[1];
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic sda_in;
    logic wp_in;

    assign sda_in    = flt_reg[1];
    assign wp_in     = syn2_reg[4];
    assign scl_rise  = flt_reg[0] && !prv_reg[0];
    assign scl_fall  = !flt_reg[0] && prv_reg[0];
    assign bus_start = flt_reg[0] && prv_reg[0] && prv_reg[1] && !flt_reg[1];
    assign bus_stop  = flt_reg[0] && prv_reg[0] && !prv_reg[1] && flt_reg[1];

    // ------------------------------------------------------------
    // Memory array and page buffer
    // ------------------------------------------------------------
    logic [7:0] mem_arr  [ees_pkg::MEM_BYTES];
    logic [7:0] page_buf [ees_pkg::PAGE_BYTES];
    logic [8:0] ptr_reg;
    logic [8:0] ptr_next;
    logic [15:0] pval_reg;
    logic [15:0] pval_next;
    logic [7:0] sh_reg;
    logic [7:0] sh_next;
    logic       pb_we;
    logic       commit;
    logic [7:0] mem_rd;

    assign mem_rd = mem_arr[ptr_reg];

    always_ff @(posedge bus.link_clk) begin
        if (pb_we) begin
            page_buf[ptr_reg[3:0]] <= sh_reg;
        end
        if (commit) begin
            for (int k = 0; k < ees_pkg::PAGE_BYTES; k++) begin
                if (pval_reg[k]) begin
                    mem_arr[{ptr_reg[8:4], 4'(k)}] <= page_buf[k];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Bus protocol state
    // ------------------------------------------------------------
    ees_dst_type st_reg;
    ees_dst_type st_next;
    logic [3:0]  bcnt_reg;
    logic [3:0]  bcnt_next;
    logic [7:0]  tx_reg;
    logic [7:0]  tx_next;
    logic        low_reg;
    logic        low_next;
    logic        pend_reg;
    logic        pend_next;
    logic [BW-1:0] busy_reg;
    logic [BW-1:0] busy_next;
    logic        busy_flag_reg;
    logic        addr_match;

    assign addr_match = (sh_reg[7:4] == TYPE_CODE)
        && (sh_reg[3:2] == syn2_reg[3:2]);

    always_comb begin
        st_next   = st_reg;
        bcnt_next = bcnt_reg;
        sh_next   = sh_reg;
        ptr_next  = ptr_reg;
        tx_next   = tx_reg;
        low_next  = low_reg;
        pend_next = pend_reg;
        pval_next = pval_reg;
        busy_next = busy_reg;
        pb_we     = 1'b0;
        commit    = 1'b0;
        if (busy_reg != '0) begin
            busy_next = busy_reg - BW'(1);
        end
        if (bus_start) begin
            st_next   = ST_DEV;
            bcnt_next = 4'h0;
            low_next  = 1'b0;
            pend_next = 1'b0;
            pval_next = 16'h0000;
        end else if (bus_stop) begin
            st_next   = ST_IDLE;
            bcnt_next = 4'h0;
            low_next  = 1'b0;
            pend_next = 1'b0;
            pval_next = 16'h0000;
            if (pend_reg && !wp_in) begin
                commit    = 1'b1;
                busy_next = BW'(WRITE_CYC);
            end
        end else if (scl_rise && st_reg != ST_IDLE) begin
            if (bcnt_reg < ees_pkg::ACK_SLOT) begin
                sh_next = {sh_reg[6:0], sda_in};
            end else if (st_reg == ST_READ && sda_in) begin
                st_next = ST_IGNORE;
            end
            bcnt_next = bcnt_reg + 4'h1;
        end else if (scl_fall && st_reg != ST_IDLE) begin
            low_next = 1'b0;
            if (bcnt_reg == ees_pkg::ACK_SLOT) begin
                case (st_reg)
                    ST_DEV: begin
                        if (addr_match && busy_reg == '0) begin
                            low_next = 1'b1;
                            if (sh_reg[ees_pkg::SA_RW_BIT]) begin
                                st_next = ST_READ;
                            end else begin
                                ptr_next[8] = sh_reg[ees_pkg::SA_HI_BIT];
                                st_next     = ST_WADDR;
                            end
                        end else begin
                            st_next = ST_IGNORE;
                        end
                    end
                    ST_WADDR: begin
                        low_next      = 1'b1;
                        ptr_next[7:0] = sh_reg;
                        st_next       = ST_WDATA;
                    end
                    ST_WDATA: begin
                        low_next               = 1'b1;
                        pb_we                  = 1'b1;
                        pval_next[ptr_reg[3:0]] = 1'b1;
                        pend_next              = 1'b1;
                        ptr_next[3:0]          = ptr_reg[3:0] + 4'h1;
                    end
                    default: begin
                    end
                endcase
            end else if (bcnt_reg == ees_pkg::FRAME_END) begin
                bcnt_next = 4'h0;
                if (st_reg == ST_READ) begin
                    tx_next  = mem_rd;
                    ptr_next = ptr_reg + 9'h001;
                    low_next = !mem_rd[7];
                end
            end else if (st_reg == ST_READ) begin
                low_next = !tx_reg[3'(4'h7 - bcnt_reg)];
            end
        end
    end

    always_ff @(posedge bus.link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg        <= ST_IDLE;
            bcnt_reg      <= 4'h0;
            sh_reg        <= 8'h00;
            ptr_reg       <= ees_pkg::PTR_RST;
            tx_reg        <= 8'h00;
            low_reg       <= ees_pkg::OE_RST;
            pend_reg      <= 1'b0;
            pval_reg      <= 16'h0000;
            busy_reg      <= '0;
            busy_flag_reg <= 1'b0;
        end else begin
            st_reg        <= st_next;
            bcnt_reg      <= bcnt_next;
            sh_reg        <= sh_next;
            ptr_reg       <= ptr_next;
            tx_reg        <= tx_next;
            low_reg       <= low_next;
            pend_reg      <= pend_next;
            pval_reg      <= pval_next;
            busy_reg      <= busy_next;
            busy_flag_reg <= (busy_next != '0);
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign bus.d_sda_o  = 1'b0;
    assign bus.d_sda_oe = low_reg;
    assign o_busy       = busy_flag_reg;
endmodule : ees_dev

/* File: hw/ees_pkg.sv */
// Shared constants for the serial memory slave and its bus master
package ees_pkg;
    // ------------------------------------------------------------
    // Clock rates
    // ------------------------------------------------------------
    localparam int unsigned CLK_KHZ      = 200000;
    localparam int unsigned LINK_CLK_KHZ = 8000;
    localparam int unsigned SCL_STD_KHZ  = 100;
    localparam int unsigned SCL_FAST_KHZ = 400;
    // ------------------------------------------------------------
    // Times and derived cycle counts
    // ------------------------------------------------------------
    // Noise suppression time constant, 0.1 us
    localparam int unsigned NOISE_NS          = 100;
    localparam int unsigned INTERNAL_WRITE_CYCLE_TIME_MS = 5;
    localparam int unsigned POWER_UP_READY_DELAY_MS      = 1;
    localparam int unsigned FILT_CYC_RAW =
        (NOISE_NS * LINK_CLK_KHZ + 999999) / 1000000;
    localparam int unsigned FILT_CYC  = (FILT_CYC_RAW < 1) ? 1 : FILT_CYC_RAW;
    localparam int unsigned WRITE_CYC = INTERNAL_WRITE_CYCLE_TIME_MS * LINK_CLK_KHZ;
    localparam int unsigned POWER_UP_CYC = POWER_UP_READY_DELAY_MS * CLK_KHZ;
    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int unsigned MEM_BYTES  = 512;
    localparam int unsigned PAGE_BYTES = 16;
    localparam int unsigned PAGES      = 32;
    localparam int unsigned ADDR_W     = 9;
    localparam int unsigned OFFS_W     = 4;
    // ------------------------------------------------------------
    // Slave address byte fields and frame positions
    // ------------------------------------------------------------
    localparam int unsigned SA_TYPE_LSB = 4;
    localparam int unsigned SA_SEL_LSB  = 2;
    localparam int unsigned SA_HI_BIT   = 1;
    localparam int unsigned SA_RW_BIT   = 0;
    localparam logic [3:0]  ACK_SLOT    = 4'h8;
    localparam logic [3:0]  FRAME_END   = 4'h9;
    // Device type code; value is arbitrary
    localparam logic [3:0]  TYPE_CODE_DEF = 4'h6;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic        OE_RST   = 1'b0;
    localparam logic [8:0]  PTR_RST  = 9'h000;
endpackage : ees_pkg

/* File: hw/ees_if.sv */
// Two-wire bus joining the memory slave and its master
interface ees_if (
    input  wire logic link_clk
);
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic d_sda_o;
    logic d_sda_oe;
    logic scl;
    logic sda;

    // Open-drain wires with pull-ups: any enabled low driver wins
    assign scl = !(m_scl_oe && !m_scl_o);
    assign sda = !(m_sda_oe && !m_sda_o) && !(d_sda_oe && !d_sda_o);

    modport dev (
        input  link_clk,
        input  scl,
        input  sda,
        output d_sda_o,
        output d_sda_oe
    );
    modport mst (
        input  sda,
        output m_scl_o,
        output m_scl_oe,
        output m_sda_o,
        output m_sda_oe
    );
endinterface : ees_if

/* File: hw/ees_mst.sv */
// Master end: makes the serial clock, byte write and random byte read
module ees_mst #(
    parameter int unsigned SCL_KHZ      = ees_pkg::SCL_FAST_KHZ,
    parameter int unsigned POWER_UP_CYC = ees_pkg::POWER_UP_CYC,
    parameter logic [3:0]  TYPE_CODE    = ees_pkg::TYPE_CODE_DEF
) (
    ees_if.mst               bus,
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_req,
    input  wire logic        i_rd,
    input  wire logic [1:0]  i_sel,
    input  wire logic [8:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    output logic             o_ready,
    output logic             o_busy,
    output logic             o_done,
    output logic             o_nack,
    output logic [7:0]       o_rdata
);
    // Quarter bit period rounded up so the rate never exceeds SCL_KHZ
    localparam int unsigned QUARTER =
        (ees_pkg::CLK_KHZ + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);
    localparam int unsigned PW = $clog2(POWER_UP_CYC + 1);

    typedef enum logic [2:0] {
        ST_PWR,
        ST_IDLE,
        ST_START,
        ST_BYTE,
        ST_STOP
    } ees_mst_type;

    function automatic logic [7:0] byte_of(input logic [2:0] step, input logic rd,
                                           input logic [1:0] sel, input logic [8:0] addr,
                                           input logic [7:0] wdata);
        case (step)
            3'h0: byte_of = {TYPE_CODE, sel, addr[8], 1'b0};
            3'h1: byte_of = addr[7:0];
            3'h2: byte_of = rd ? {TYPE_CODE, sel, addr[8], 1'b1} : wdata;
            default: byte_of = 8'hff;
        endcase
    endfunction : byte_of

    // ------------------------------------------------------------
    // Data line synchroniser
    // ------------------------------------------------------------
    logic s1_reg;
    logic s2_reg;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
        end else begin
            s1_reg <= bus.sda;
            s2_reg <= s1_reg;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    ees_mst_type st_reg, st_next;
    logic [PW-1:0] pu_reg, pu_next;
    logic [15:0]   div_reg, div_next;
    logic [1:0]    q_reg, q_next;
    logic [3:0]    bit_reg, bit_next;
    logic [2:0]    step_reg, step_next;
    logic          scl_oe_reg, scl_oe_next;
    logic          sda_oe_reg, sda_oe_next;
    logic          rd_reg, rd_next;
    logic [1:0]    sel_reg, sel_next;
    logic [8:0]    addr_reg, addr_next;
    logic [7:0]    wd_reg, wd_next;
    logic [7:0]    rsh_reg, rsh_next;
    logic          ackn_reg, ackn_next;
    logic          ready_reg, ready_next;
    logic          busy_reg, busy_next;
    logic          done_reg, done_next;
    logic          nack_reg, nack_next;
    logic [7:0]    rdata_reg, rdata_next;
    logic          tick;
    logic          tx_byte;
    logic [7:0]    cur;
    logic [2:0]    last_step;

    assign tick      = (div_reg == 16'(QUARTER - 1));
    assign tx_byte   = !(rd_reg && step_reg == 3'h3);
    assign cur       = byte_of(step_reg, rd_reg, sel_reg, addr_reg, wd_reg);
    assign last_step = rd_reg ? 3'h3 : 3'h2;

    always_comb begin
        st_next = st_reg;      pu_next = pu_reg;       div_next = div_reg;
        q_next = q_reg;        bit_next = bit_reg;     step_next = step_reg;
        scl_oe_next = scl_oe_reg;  sda_oe_next = sda_oe_reg;
        rd_next = rd_reg;      sel_next = sel_reg;     addr_next = addr_reg;
        wd_next = wd_reg;      rsh_next = rsh_reg;     ackn_next = ackn_reg;
        ready_next = ready_reg;    busy_next = busy_reg;   done_next = 1'b0;
        nack_next = nack_reg;  rdata_next = rdata_reg;
        if (st_reg == ST_START || st_reg == ST_BYTE || st_reg == ST_STOP) begin
            div_next = tick ? 16'h0000 : div_reg + 16'h0001;
            if (tick) begin
                q_next = q_reg + 2'h1;
            end
        end
        case (st_reg)
            ST_PWR: begin
                if (pu_reg == PW'(POWER_UP_CYC - 1)) begin
                    st_next    = ST_IDLE;
                    ready_next = 1'b1;
                end else begin
                    pu_next = pu_reg + PW'(1);
                end
            end
            ST_IDLE: begin
                if (i_req) begin
                    rd_next = i_rd;   sel_next = i_sel;  addr_next = i_addr;  wd_next = i_wdata;
                    busy_next = 1'b1; nack_next = 1'b0;  step_next = 3'h0;
                    q_next = 2'h0;    div_next = 16'h0000;
                    st_next = ST_START;
                end
            end
            ST_START: begin
                if (tick) begin
                    case (q_reg)
                        2'h0: sda_oe_next = 1'b0;
                        2'h1: scl_oe_next = 1'b0;
                        2'h2: sda_oe_next = 1'b1;
                        default: begin
                            scl_oe_next = 1'b1;
                            bit_next    = 4'h0;
                            st_next     = ST_BYTE;
                        end
                    endcase
                end
            end
            ST_BYTE: begin
                if (tick) begin
                    case (q_reg)
                        2'h0: sda_oe_next = (bit_reg < 4'h8 && tx_byte) ? !cur[3'(4'h7 - bit_reg)] : 1'b0;
                        2'h1: scl_oe_next = 1'b0;
                        2'h2: begin
                            if (bit_reg < 4'h8) begin
                                rsh_next = {rsh_reg[6:0], s2_reg};
                            end else begin
                                ackn_next = s2_reg;
                            end
                        end
                        default: begin
                            scl_oe_next = 1'b1;
                            bit_next    = bit_reg + 4'h1;
                            if (bit_reg == 4'h8) begin
                                bit_next = 4'h0;
                                if (tx_byte && ackn_reg) begin
                                    nack_next = 1'b1;
                                    st_next   = ST_STOP;
                                end else if (step_reg == last_step) begin
                                    st_next = ST_STOP;
                                end else begin
                                    step_next = step_reg + 3'h1;
                                    if (rd_reg && step_reg == 3'h1) begin
                                        st_next = ST_START;
                                    end
                                end
                            end
                        end
                    endcase
                end
            end
            ST_STOP: begin
                if (tick) begin
                    case (q_reg)
                        2'h0: sda_oe_next = 1'b1;
                        2'h1: scl_oe_next = 1'b0;
                        2'h2: sda_oe_next = 1'b0;
                        default: begin
                            st_next    = ST_IDLE;
                            busy_next  = 1'b0;
                            done_next  = 1'b1;
                            rdata_next = rsh_reg;
                        end
                    endcase
                end
            end
            default: st_next = ST_PWR;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= ST_PWR;  pu_reg <= '0;  div_reg <= 16'h0000;  q_reg <= 2'h0;
            bit_reg <= 4'h0;   step_reg <= 3'h0;
            scl_oe_reg <= ees_pkg::OE_RST;  sda_oe_reg <= ees_pkg::OE_RST;
            rd_reg <= 1'b0;    sel_reg <= 2'h0;  addr_reg <= 9'h000;  wd_reg <= 8'h00;
            rsh_reg <= 8'h00;  ackn_reg <= 1'b0; ready_reg <= 1'b0;   busy_reg <= 1'b0;
            done_reg <= 1'b0;  nack_reg <= 1'b0; rdata_reg <= 8'h00;
        end else begin
            st_reg <= st_next;  pu_reg <= pu_next;  div_reg <= div_next;  q_reg <= q_next;
            bit_reg <= bit_next;  step_reg <= step_next;
            scl_oe_reg <= scl_oe_next;  sda_oe_reg <= sda_oe_next;
            rd_reg <= rd_next;  sel_reg <= sel_next;  addr_reg <= addr_next;  wd_reg <= wd_next;
            rsh_reg <= rsh_next;  ackn_reg <= ackn_next;  ready_reg <= ready_next;
            busy_reg <= busy_next;  done_reg <= done_next;  nack_reg <= nack_next;
            rdata_reg <= rdata_next;
        end
    end

    assign bus.m_scl_o  = 1'b0;
    assign bus.m_sda_o  = 1'b0;
    assign bus.m_scl_oe = scl_oe_reg;
    assign bus.m_sda_oe = sda_oe_reg;
    assign o_ready      = ready_reg;
    assign o_busy       = busy_reg;
    assign o_done       = done_reg;
    assign o_nack       = nack_reg;
    assign o_rdata      = rdata_reg;
endmodule : ees_mst

/* File: verification/ees_asserts.sv */
// Link checks between the memory slave and its master
module ees_asserts #(
    parameter int unsigned WRITE_CYC = 200
) (
    input wire logic link_clk,
    input wire logic i_rst_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic d_sda_o,
    input wire logic d_sda_oe,
    input wire logic o_busy,
    input wire logic i_wp
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] busy_cnt_reg;
    logic [31:0] busy_cnt_next;
    default clocking @(posedge link_clk); endclocking
    default disable iff (!i_rst_n);
    // ----------------------------------------
    // Write cycle length counter
    // ----------------------------------------
    always_comb busy_cnt_next = o_busy ? busy_cnt_reg + 32'h1 : 32'h0;
    always_ff @(posedge link_clk or negedge i_rst_n) begin
        if (!i_rst_n) busy_cnt_reg <= 32'h0;
        else busy_cnt_reg <= busy_cnt_next;
    end
    pull_low_only_a: assert property (d_sda_oe |-> !d_sda_o) else $error("data high");
    change_clk_low_a: assert property ($changed(d_sda_oe) |-> !scl && !$past(scl)) else $error("sda moved");
    busy_no_ack_a: assert property (o_busy |-> !d_sda_oe) else $error("ack while busy");
    wp_no_write_a: assert property ($rose(o_busy) |-> !i_wp) else $error("protected write");
    busy_on_stop_a: assert property ($rose(o_busy) |-> scl && sda) else $error("busy no stop");
    busy_length_a: assert property ($fell(o_busy) |-> busy_cnt_reg == WRITE_CYC) else $error("busy len");
    scl_low_time_a: assert property ($fell(scl) |-> !scl [*8]) else $error("scl low short");
    scl_high_time_a: assert property ($rose(scl) |-> scl [*4]) else $error("scl high short");
    cover property ($rose(o_busy));
    cover property ($rose(d_sda_oe));
    cover property (scl && $fell(sda));
endmodule : ees_asserts

/* File: verification/ees_tb.sv */
// Bench joining the memory slave and its master over the link
module i2c_serial_eeprom_slave_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned WCYC = 600;
    logic clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0, req = 1'b0, rd = 1'b0, wp = 1'b0;
    logic [1:0] msel = 2'h0, dsel = 2'h0;
    logic [8:0] addr = 9'h000;
    logic [7:0] wdata = 8'h00, rdata, dval;
    logic ready, mbusy, done, nack, dbusy;
    logic [31:0] rnd = 32'hc95c47d7;
    int mismatches = 0;
    int tests_run = 0;
    ees_if u_bus (.link_clk(link_clk));
    ees_dev #(.WRITE_CYC(WCYC)) u_ees_dev (.bus(u_bus.dev), .i_rst_n(rst_n), .i_wp(wp), .i_sel(dsel), .o_busy(dbusy));
    ees_mst #(.POWER_UP_CYC(50)) u_ees_mst (.bus(u_bus.mst), .i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_rd(rd),
        .i_sel(msel), .i_addr(addr), .i_wdata(wdata), .o_ready(ready), .o_busy(mbusy), .o_done(done), .o_nack(nack),
        .o_rdata(rdata));
    ees_asserts #(.WRITE_CYC(WCYC)) u_ees_asserts (.link_clk(link_clk), .i_rst_n(rst_n), .scl(u_bus.scl),
        .sda(u_bus.sda), .d_sda_o(u_bus.d_sda_o), .d_sda_oe(u_bus.d_sda_oe), .o_busy(dbusy), .i_wp(wp));
    initial forever #2.5 clk = ~clk;
    initial begin
        #37;
        forever #62.5 link_clk = ~link_clk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    task automatic reset_pulse();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (16) @(posedge link_clk);
        @(posedge clk);
        rst_n <= 1'b1;
    endtask : reset_pulse
    task automatic xfer(input logic r, input logic [1:0] s, input logic [7:0] d);
        int n;
        n = 0;
        while ((ready !== 1'b1 || mbusy !== 1'b0) && n < 40000) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        req <= 1'b1;
        rd <= r;
        msel <= s;
        wdata <= d;
        @(posedge clk);
        req <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 40000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 40000) mismatches++;
    endtask : xfer
    initial begin
        int n;
        n = 0;
        reset_pulse();
        rnd = lfsr(rnd);
        dsel <= rnd[1:0];
        addr <= {1'b1, rnd[15:8]};
        dval = rnd[23:16];
        xfer(1'b0, rnd[1:0], dval);
        check(nack, 1'b0);
        repeat (8) @(posedge link_clk);
        check(dbusy, 1'b1);
        xfer(1'b0, dsel, ~dval);
        check(nack, 1'b1);
        while (dbusy !== 1'b0 && n < 40000) begin
            @(negedge clk);
            n++;
        end
        $display("test 1 end");
        for (int k = 1; k < 4; k++) begin
            xfer(1'b0, dsel ^ 2'(k), ~dval);
            check(nack, 1'b1);
        end
        $display("test 2 end");
        @(posedge clk);
        wp <= 1'b1;
        xfer(1'b0, dsel, ~dval);
        repeat (8) @(posedge link_clk);
        check(dbusy, 1'b0);
        @(posedge clk);
        wp <= 1'b0;
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        repeat (2000) @(posedge clk);
        reset_pulse();
        @(negedge clk);
        check(dbusy, 1'b0);
        check(ready, 1'b0);
        $display("test 3 end");
        xfer(1'b1, dsel, 8'h00);
        check(rdata, dval);
        $display("test 4 end");
        give_verdict();
    end
    initial begin
        repeat (110000) @(posedge clk);
        mismatches++;
        give_verdict();
    end
endmodule : i2c_serial_eeprom_slave_tb
